/* File: phy_mgmt_pkg.sv */
// Constants and carrier types for the basic management register bank.
// Assumes a single 10 MHz system clock; management pins arrive asynchronously.
package phy_mgmt_pkg;

    // ----------------------------------------------------------------
    // Register addresses
    // ----------------------------------------------------------------
    localparam logic [4:0] REG_CONTROL = 5'h00;
    localparam logic [4:0] REG_STATUS = 5'h01;
    localparam logic [4:0] REG_ID_HIGH = 5'h02;

    // ----------------------------------------------------------------
    // Control register fields
    // ----------------------------------------------------------------
    localparam int CTL_RESET = 15;
    localparam int CTL_ANEG_RESTART = 9;
    localparam int CTL_ISOLATE = 10;
    localparam logic [15:0] CTRL_RW_MASK = 16'h7D80;
    localparam logic [15:0] CTRL_RESET_VAL = 16'h3100;

    // ----------------------------------------------------------------
    // Status register fields
    // ----------------------------------------------------------------
    localparam int STS_T4 = 15;
    localparam int STS_PRE_SUPP = 6;
    localparam int STS_ANEG_DONE = 5;
    localparam int STS_REM_FAULT = 4;
    localparam int STS_LINK = 2;
    localparam int STS_JABBER = 1;
    localparam int STS_EXT_CAP = 0;
    localparam logic [15:0] STATUS_FIXED = 16'h7809;

    // ----------------------------------------------------------------
    // Management frame layout
    // ----------------------------------------------------------------
    localparam logic [5:0] PREAMBLE_BITS = 6'h20;
    localparam logic [4:0] HDR_LAST = 5'h0C;
    localparam logic [4:0] DATA_LAST = 5'h11;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] STRAP_WAIT = 2'h2;

    typedef enum logic [1:0] {
        MF_PRE = 2'h0,
        MF_HDR = 2'h1,
        MF_DATA = 2'h3
    } mf_state_t;

    // Events from the line-side engines
    typedef struct packed {
        logic anDone;
        logic remoteFault;
        logic linkUp;
        logic jabber;
    } phy_events_t;

    // Pulses toward the rest of the device
    typedef struct packed {
        logic swReset;
        logic anegRestart;
    } phy_pulses_t;

endpackage

/* File: phy_basic_mgmt_registers.sv */
// Basic management register bank: control, status and first identifier word,
// reached over the serial management_frame bus (clock and data pins).
// Assumes clock pin at most a quarter of sys_clk; straps static around reset.
//
// Overview of operation
// - Isolate bit set disconnects the reduced data interface; reset value comes from strap.
// - Negotiation-complete status bit latches high on completion, clears when read.
// - Remote-fault status bit latches high on a far-end fault, clears when read.
// - Preamble suppression reads zero; every frame needs a full 32-bit preamble.
// - Extended-capability status bit always reads one.
// - Four-pair 100 Mb/s capability bit always reads zero; writes ignored.
// - Strapped management address zero keeps the reduced data interface high impedance.
`timescale 1ns/10ps
module phy_basic_mgmt_registers
    import phy_mgmt_pkg::*;
#(
    parameter logic [15:0] ID_HIGH = 16'h5A5A // Arbitrary identifier value
) (
    input wire logic sys_clk, // 10 MHz system clock
    input wire logic sys_rst, // Async reset, active high
    input wire logic mgmtClk, // Management clock pin
    input wire logic mgmtDataIn, // Management data pin, input side
    output logic mgmtDataOut, // Management data pin, output side
    output logic mgmtDataOe, // Management data pin drive enable
    input wire logic [4:0] addrStrap, // Address strap pins
    input wire logic isoStrap, // Isolate strap pin
    input wire phy_events_t events, // Line-side status events
    output logic [15:0] control, // Control register contents
    output phy_pulses_t pulses, // One-cycle action pulses
    output logic rmiiHiZ // Reduced data interface tristate
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0] clkSync;
        logic [1:0] dataSync;
        logic clkPrev;
        logic [4:0] addrMeta;
        logic [4:0] addrSync;
        logic [1:0] isoSync;
        logic [1:0] strapCnt;
        logic strapped;
        logic [4:0] phyAddr;
        mf_state_t mode;
        logic [5:0] preCnt;
        logic [4:0] bitCnt;
        logic [12:0] hdr;
        logic isRead;
        logic hit;
        logic [4:0] regAddr;
        logic [15:0] shift;
        logic dOut;
        logic dOe;
        logic [15:0] ctrl;
        logic anDoneL;
        logic faultL;
        logic linkL;
        logic jabberL;
        logic swReset;
        logic restart;
        logic hiZ;
    } mgmt_state_t;

    mgmt_state_t s;
    mgmt_state_t next_s;
    logic mdcRise;
    logic bitIn;
    logic [12:0] hdrFull;
    logic hdrDone;
    logic statusRead;
    logic [15:0] statusWord;
    logic [15:0] readWord;

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        next_s = s;
        // Pin synchronisers; first stage feeds only the second
        next_s.clkSync = {s.clkSync[0], mgmtClk};
        next_s.dataSync = {s.dataSync[0], mgmtDataIn};
        next_s.clkPrev = s.clkSync[1];
        next_s.addrMeta = addrStrap;
        next_s.addrSync = s.addrMeta;
        next_s.isoSync = {s.isoSync[0], isoStrap};
        next_s.swReset = 1'b0;
        next_s.restart = 1'b0;
        mdcRise = s.clkSync[1] & ~s.clkPrev;
        bitIn = s.dataSync[1];
        hdrFull = {s.hdr[11:0], bitIn};
        hdrDone = 1'b0;
        statusRead = 1'b0;

        // Read values
        statusWord = STATUS_FIXED;
        statusWord[STS_T4] = 1'b0;
        statusWord[STS_EXT_CAP] = 1'b1;
        statusWord[STS_PRE_SUPP] = 1'b0;
        statusWord[STS_ANEG_DONE] = s.anDoneL;
        statusWord[STS_REM_FAULT] = s.faultL;
        statusWord[STS_LINK] = s.linkL;
        statusWord[STS_JABBER] = s.jabberL;
        case (hdrFull[4:0])
            REG_CONTROL: readWord = s.ctrl;
            REG_STATUS: readWord = statusWord;
            REG_ID_HIGH: readWord = ID_HIGH;
            default: readWord = 16'h0000;
        endcase

        // Strap capture a few cycles after reset release
        if (!s.strapped) begin
            next_s.strapCnt = s.strapCnt + 2'h1;
            if (s.strapCnt == STRAP_WAIT) begin
                next_s.strapped = 1'b1;
                next_s.phyAddr = s.addrSync;
                next_s.ctrl[CTL_ISOLATE] = s.isoSync[1];
            end
        end

        // Frame engine, one step per management clock rising edge
        if (mdcRise) begin
            case (s.mode)
                MF_PRE: begin
                    if (bitIn) begin
                        if (s.preCnt != PREAMBLE_BITS) begin
                            next_s.preCnt = s.preCnt + 6'h1;
                        end
                    end else if (s.preCnt == PREAMBLE_BITS) begin
                        next_s.mode = MF_HDR;
                        next_s.bitCnt = 5'h00;
                        next_s.preCnt = 6'h00;
                    end else begin
                        next_s.preCnt = 6'h00;
                    end
                end
                MF_HDR: begin
                    next_s.hdr = hdrFull;
                    next_s.bitCnt = s.bitCnt + 5'h01;
                    if (s.bitCnt == HDR_LAST) begin
                        hdrDone = 1'b1;
                        next_s.bitCnt = 5'h00;
                        next_s.regAddr = hdrFull[4:0];
                        next_s.hit = hdrFull[12] & s.strapped & (hdrFull[9:5] == s.phyAddr)
                            & ((hdrFull[11:10] == OP_READ) | (hdrFull[11:10] == OP_WRITE));
                        next_s.isRead = hdrFull[11:10] == OP_READ;
                        next_s.shift = readWord;
                        next_s.mode = MF_DATA;
                        statusRead = next_s.hit & next_s.isRead & (hdrFull[4:0] == REG_STATUS);
                    end
                end
                MF_DATA: begin
                    next_s.bitCnt = s.bitCnt + 5'h01;
                    if (s.isRead && s.hit) begin
                        // Second turnaround bit driven low, then data MSB first
                        next_s.dOe = s.bitCnt != DATA_LAST;
                        next_s.dOut = (s.bitCnt == 5'h00) ? 1'b0 : s.shift[15];
                        if (s.bitCnt != 5'h00) begin
                            next_s.shift = {s.shift[14:0], 1'b0};
                        end
                    end else if (s.bitCnt >= 5'h02) begin
                        next_s.shift = {s.shift[14:0], bitIn};
                    end
                    if (s.bitCnt == DATA_LAST) begin
                        next_s.mode = MF_PRE;
                        next_s.dOe = 1'b0;
                        next_s.dOut = 1'b0;
                        if (!s.isRead && s.hit && s.regAddr == REG_CONTROL) begin
                            next_s.ctrl = {s.shift[14:0], bitIn} & CTRL_RW_MASK;
                            next_s.restart = s.shift[CTL_ANEG_RESTART - 1];
                            next_s.swReset = s.shift[CTL_RESET - 1];
                        end
                    end
                end
                default: next_s.mode = MF_PRE;
            endcase
        end

        // Software reset restores control defaults, keeps the strapped isolate
        if (s.swReset) begin
            next_s.ctrl = CTRL_RESET_VAL;
            next_s.ctrl[CTL_ISOLATE] = s.isoSync[1];
        end

        // Latched status bits; a new event wins over the read clear
        next_s.anDoneL = (s.anDoneL & ~statusRead) | events.anDone;
        next_s.faultL = (s.faultL & ~statusRead) | events.remoteFault;
        next_s.jabberL = (s.jabberL & ~statusRead) | events.jabber;
        next_s.linkL = statusRead ? events.linkUp : (s.linkL & events.linkUp);
        if (s.swReset) begin
            next_s.anDoneL = events.anDone;
            next_s.faultL = events.remoteFault;
            next_s.jabberL = events.jabber;
            next_s.linkL = events.linkUp;
        end

        // Data interface tristate from isolate or address zero
        next_s.hiZ = next_s.ctrl[CTL_ISOLATE] | (next_s.strapped & (next_s.phyAddr == 5'h00));
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s <= '0;
            s.mode <= MF_PRE;
            s.ctrl <= CTRL_RESET_VAL;
            s.hiZ <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // Outputs
    assign mgmtDataOut = s.dOut;
    assign mgmtDataOe = s.dOe;
    assign control = s.ctrl;
    assign pulses = '{swReset: s.swReset, anegRestart: s.restart};
    assign rmiiHiZ = s.hiZ;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_isolate;
        @(posedge sys_clk) disable iff (sys_rst) s.ctrl[CTL_ISOLATE] |-> rmiiHiZ;
    endproperty
    a_isolate: assert property (p_isolate) else $error("isolate set but interface driven");

    property p_addr_zero;
        @(posedge sys_clk) disable iff (sys_rst) (s.strapped && s.phyAddr == 5'h00) |-> rmiiHiZ;
    endproperty
    a_addr_zero: assert property (p_addr_zero) else $error("address zero but interface driven");

    property p_aneg_latch;
        @(posedge sys_clk) disable iff (sys_rst) (events.anDone && !s.swReset) |=> s.anDoneL;
    endproperty
    a_aneg_latch: assert property (p_aneg_latch) else $error("completion not latched");

    property p_fault_latch;
        @(posedge sys_clk) disable iff (sys_rst)
            (s.faultL && !statusRead && !s.swReset) |=> s.faultL;
    endproperty
    a_fault_latch: assert property (p_fault_latch) else $error("remote fault dropped before read");

    property p_preamble;
        @(posedge sys_clk) disable iff (sys_rst)
            (s.mode == MF_PRE && next_s.mode == MF_HDR) |-> s.preCnt == PREAMBLE_BITS;
    endproperty
    a_preamble: assert property (p_preamble) else $error("frame accepted without full preamble");

    property p_ext_cap;
        @(posedge sys_clk) disable iff (sys_rst) statusRead |=> s.shift[STS_EXT_CAP] && !s.shift[STS_PRE_SUPP];
    endproperty
    a_ext_cap: assert property (p_ext_cap) else $error("status snapshot fixed bits wrong");

    property p_t4_zero;
        @(posedge sys_clk) disable iff (sys_rst) statusRead |=> !s.shift[STS_T4];
    endproperty
    a_t4_zero: assert property (p_t4_zero) else $error("four-pair capability reads one");

    property p_self_clear;
        @(posedge sys_clk) disable iff (sys_rst)
            (s.swReset || s.restart) |=> !s.swReset && !s.restart && !s.ctrl[CTL_RESET] ##1 !s.swReset;
    endproperty
    a_self_clear: assert property (p_self_clear) else $error("action bit did not self-clear");

    c_status_read: cover property (@(posedge sys_clk) disable iff (sys_rst) statusRead);
    c_sw_reset: cover property (@(posedge sys_clk) disable iff (sys_rst) s.swReset);
    c_read_drive: cover property (@(posedge sys_clk) disable iff (sys_rst) $rose(mgmtDataOe));
    c_refused: cover property (@(posedge sys_clk) disable iff (sys_rst) hdrDone && !next_s.hit);

endmodule // phy_basic_mgmt_registers

/* File: mgmt_station_model.sv */
// Station management controller model driving framed accesses on the clock/data pins.
// Assumes the bench gives sys_clk; line resolved here with a pull-up when idle.
`timescale 1ns/10ps
module mgmt_station_model
    import phy_mgmt_pkg::*;
(
    input wire logic sys_clk, // Pacing clock
    input wire logic devOut, // Device data output
    input wire logic devOe, // Device drive enable
    output logic mgmtClk, // Management clock to device
    output logic mdio // Resolved data line
);
    logic hostBit;
    logic hostOe;

    // Line level: device, then host, else pull-up
    assign mdio = devOe ? devOut : (hostOe ? hostBit : 1'h1);

    initial begin
        mgmtClk = 1'h0;
        hostBit = 1'h1;
        hostOe = 1'h1;
    end

    // One bit: data set while low, sampled at the rise, clock parks low
    task automatic tick(input logic b, output logic s);
        hostBit = b;
        repeat (4) @(negedge sys_clk);
        s = mdio;
        mgmtClk = 1'h1;
        repeat (4) @(negedge sys_clk);
        mgmtClk = 1'h0;
    endtask

    // -----------------------------------------------------------
    // Whole frame: preamble, header, turnaround, 16 data bits
    // -----------------------------------------------------------
    task automatic frame(input int preLen, input logic [1:0] op, input logic [4:0] phy,
                         input logic [4:0] regAddr, input logic [15:0] wdata, output logic [15:0] rdata);
        logic s;
        logic [13:0] hdr;
        hdr = {2'h1, op, phy, regAddr};
        hostOe = 1'h1;
        rdata = 16'h0000;
        for (int i = 0; i < preLen; i++) tick(1'h1, s);
        for (int i = 13; i >= 0; i--) tick(hdr[i], s);
        if (op == OP_READ) begin
            hostOe = 1'h0;
            tick(1'h1, s);
            tick(1'h1, s);
            for (int i = 15; i >= 0; i--) begin
                tick(1'h1, s);
                rdata[i] = s;
            end
            hostOe = 1'h1;
        end else begin
            tick(1'h1, s);
            tick(1'h0, s);
            for (int i = 15; i >= 0; i--) tick(wdata[i], s);
        end
        hostBit = 1'h1;
        repeat (8) @(negedge sys_clk);
    endtask
endmodule // mgmt_station_model

/* File: phy_basic_mgmt_registers_bench.sv */
// Self-checking bench for the basic management register bank.
// Assumes the station model file and the package are compiled first.
`timescale 1ns/10ps
`define CHK(a, e) begin numChecks++; if ((a) !== (e)) begin mismatches++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module phy_basic_mgmt_registers_bench
    import phy_mgmt_pkg::*;
;
    localparam logic [15:0] ID_VAL = 16'hA55A; // Arbitrary identifier value
    localparam logic [4:0] PHY_ADDR = 5'h01;
    logic sys_clk, sys_rst, mgmtClk, mdio, dataOut, dataOe, rmiiHiZ, hiZero;
    logic [15:0] control, ctlZero;
    phy_events_t events;
    phy_pulses_t pulses;
    int mismatches = 0, numChecks = 0, restarts = 0, swResets = 0;

    // -----------------------------------------------------------
    // Instances
    // -----------------------------------------------------------
    phy_basic_mgmt_registers #(.ID_HIGH(ID_VAL)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .mgmtClk(mgmtClk), .mgmtDataIn(mdio), .mgmtDataOut(dataOut), .mgmtDataOe(dataOe),
        .addrStrap(PHY_ADDR), .isoStrap(1'h1), .events(events), .control(control),
        .pulses(pulses), .rmiiHiZ(rmiiHiZ));
    phy_basic_mgmt_registers dutZero (.sys_clk(sys_clk), .sys_rst(sys_rst), .mgmtClk(mgmtClk),
        .mgmtDataIn(mdio), .mgmtDataOut(), .mgmtDataOe(), .addrStrap(5'h00), .isoStrap(1'h0),
        .events(events), .control(ctlZero), .pulses(), .rmiiHiZ(hiZero));
    mgmt_station_model sta (.sys_clk(sys_clk), .devOut(dataOut), .devOe(dataOe),
        .mgmtClk(mgmtClk), .mdio(mdio));

    // Clock and action pulse counters
    initial begin
        sys_clk = 1'h0;
        forever #50 sys_clk = ~sys_clk;
    end
    always @(negedge sys_clk) begin
        if (pulses.anegRestart === 1'h1) restarts++;
        if (pulses.swReset === 1'h1) swResets++;
    end

    task automatic rd(input logic [4:0] r, output logic [15:0] v);
        sta.frame(32, OP_READ, PHY_ADDR, r, 16'h0000, v);
    endtask
    task automatic wr(input logic [4:0] r, input logic [15:0] v);
        logic [15:0] d;
        sta.frame(32, OP_WRITE, PHY_ADDR, r, v, d);
    endtask

    // -----------------------------------------------------------
    // Scenarios
    // -----------------------------------------------------------
    task automatic t_defaults();
        logic [15:0] v;
        `CHK(control, 16'h3500)
        `CHK(rmiiHiZ, 1'h1)
        `CHK({hiZero, ctlZero[10]}, 2'h2)
        rd(REG_CONTROL, v);
        `CHK(v, 16'h3500)
        rd(REG_ID_HIGH, v);
        `CHK(v, ID_VAL)
        rd(5'h05, v);
        `CHK(v, 16'h0000)
    endtask

    task automatic t_status();
        logic [15:0] v;
        rd(REG_STATUS, v);
        `CHK(v, 16'h7809)
        wr(REG_STATUS, 16'hFFFF);
        rd(REG_STATUS, v);
        `CHK(v, 16'h7809)
        sta.frame(32, OP_READ, 5'h03, REG_STATUS, 16'h0000, v);
        `CHK(v, 16'hFFFF)
    endtask

    task automatic t_latch();
        logic [15:0] v;
        @(negedge sys_clk);
        events.anDone = 1'h1;
        events.remoteFault = 1'h1;
        @(negedge sys_clk);
        events = '0;
        rd(REG_STATUS, v);
        `CHK(v, 16'h7839)
        rd(REG_STATUS, v);
        `CHK(v, 16'h7809)
    endtask

    task automatic t_isolate();
        wr(REG_CONTROL, 16'h3100);
        `CHK({control, rmiiHiZ}, {16'h3100, 1'h0})
        wr(REG_CONTROL, 16'h3500);
        `CHK({control, rmiiHiZ}, {16'h3500, 1'h1})
    endtask

    task automatic t_self_clear();
        int n0, s0;
        n0 = restarts;
        s0 = swResets;
        wr(REG_CONTROL, 16'h3301);
        `CHK(restarts - n0, 1)
        `CHK(control, 16'h3100)
        wr(REG_CONTROL, 16'h2100);
        `CHK(restarts - n0 + swResets - s0, 1)
        wr(REG_CONTROL, 16'h8000);
        `CHK(swResets - s0, 1)
        `CHK(control, 16'h3500)
    endtask

    task automatic t_short_pre();
        logic [15:0] d;
        sta.frame(31, OP_WRITE, PHY_ADDR, REG_CONTROL, 16'h2100, d);
        `CHK(control, 16'h3500)
        wr(REG_CONTROL, 16'h2100);
        `CHK(control, 16'h2100)
        // Unknown operation code is consumed without a write
        sta.frame(32, 2'h3, PHY_ADDR, REG_CONTROL, 16'h0000, d);
        `CHK(control, 16'h2100)
    endtask

    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", numChecks, mismatches);
        if (mismatches == 0 && numChecks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        sys_rst = 1'h1;
        events = '0;
        repeat (3) @(negedge sys_clk);
        sys_rst = 1'h0;
        repeat (10) @(negedge sys_clk);
        t_defaults();
        t_status();
        t_latch();
        t_isolate();
        t_self_clear();
        t_short_pre();
        wrap_up();
    end

    // Watchdog well beyond the expected run
    initial begin
        #5000000;
        mismatches++;
        wrap_up();
    end
endmodule // phy_basic_mgmt_registers_bench
